// ### src/vgc_pkg.sv
// constants, types and helpers shared by both ends of the gain-control link
// assumes a 20 MHz system clock on each end
// Overview of operation
// RULE1: two strap pins choose parallel, basic or extended
// RULE2: parallel strobe high passes gain word through
// RULE3: strobe falling edge freezes the attenuation word
// RULE4: factory curve weights bits 16 down to 0.5 dB
// RULE5: basic mode shifts into six-bit gain word
// RULE6: basic mode daisy-chains; first word goes farthest
// RULE7: basic strobe rising edge applies shifted word
// RULE8: extended frame is command byte then data
// RULE9: data bit 7 high reads, low writes
// RULE10: extended read replaces output data with register
// RULE11: command zero holds six-bit gain word, reset zero
// RULE12: temperature status read-only, bit 7 reads one
// RULE13: four-bit temperature code, extended mode only
// RULE14: threshold in bits 3:0, actions bits 6:4
// RULE15: rf select plus over-temperature switches rf off
// RULE16: preset select plus over-temperature uses strap gain
// RULE17: min-gain select plus over-temperature drops gain
// RULE18: enable bits: sensor, amplifier, attenuator; reset 0x3f
// RULE19: top bits 10 write curve entry; linear reset
// RULE20: chip type read returns fixed identification byte
// RULE21: power-up straps choose one of four gains
// RULE22: power-up gain from parallel word or straps
// RULE23: msb first, rising clock sample, displaced bits out
package vgc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_PERIOD_NS = 400;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  // ==========================================================
  // frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam int RW_BIT = 7;
  // ==========================================================
  // extended commands
  localparam logic [7:0] CMD_GAIN_SELECT = 8'h00;
  localparam logic [7:0] CMD_TEMP_CODE = 8'h10;
  localparam logic [7:0] CMD_THERMAL_CFG = 8'h11;
  localparam logic [7:0] CMD_BLOCK_EN = 8'h50;
  localparam logic [7:0] CMD_PART_ID = 8'hf0;
  localparam logic [1:0] CMD_CURVE_TOP = 2'h2;
  localparam logic [7:0] TEMP_STATUS_FLAG = 8'h80;
  // ==========================================================
  // field positions and reset values
  localparam int CFG_RF_BIT = 6;
  localparam int CFG_PG_BIT = 5;
  localparam int CFG_MG_BIT = 4;
  localparam int EN_TS_BIT = 0;
  localparam int EN_AM_BIT = 1;
  localparam int EN_AT_BIT = 2;
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [5:0] EN_RESET = 6'h3f;
  localparam logic [5:0] MIN_GAIN_WORD = 6'h00;
  // arbitrary identification value
  localparam logic [7:0] PART_ID_DEFAULT = 8'h5a;
  // ==========================================================
  // host register map
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_PAR = 2'h1;
  localparam logic [1:0] HREG_TX = 2'h2;
  localparam logic [1:0] HREG_STAT = 2'h3;
  localparam int CTRL_ISEL_BIT = 0;
  localparam int CTRL_VAR_BIT = 1;
  localparam int CTRL_PUPLO_BIT = 2;
  localparam int CTRL_PUPHI_BIT = 3;
  localparam int CTRL_LE_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h10;
  localparam int STAT_BUSY_BIT = 16;
  // ==========================================================
  // host serial engine states
  typedef enum logic [3:0] {
    VGC_IDLE = 4'b0001,
    VGC_LOW = 4'b0010,
    VGC_HIGH = 4'b0100,
    VGC_LATCH = 4'b1000
  } vgc_state_t;

  // strap pair to start-up gain word (-31.5, -24, -16 and 0 dB gain)
  function automatic logic [5:0] vgc_preset(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: vgc_preset = 6'h00;
      2'b01: vgc_preset = 6'h0f;
      2'b10: vgc_preset = 6'h1f;
      default: vgc_preset = 6'h3f;
    endcase
  endfunction

  // wishbone byte-lane merge
  function automatic logic [31:0] vgc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      vgc_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction
endpackage

// ### src/vgc_link_if.sv
// pins between the gain-control device and its host controller
// assumes the bench drives no pin itself
`timescale 1ns/100ps
`default_nettype none
interface vgc_link_if;
  logic interface_select_pin;
  logic spi_variant_pin;
  logic powerup_gain_hi;
  logic powerup_gain_lo;
  logic latch_enable_select;
  logic [5:0] gain_word_bits;
  logic spi_clk;
  logic serial_data_in;
  logic serial_data_out;

  modport dev (
    input interface_select_pin, spi_variant_pin, powerup_gain_hi, powerup_gain_lo,
    input latch_enable_select, gain_word_bits, spi_clk, serial_data_in,
    output serial_data_out
  );
  modport host (
    output interface_select_pin, spi_variant_pin, powerup_gain_hi, powerup_gain_lo,
    output latch_enable_select, gain_word_bits, spi_clk, serial_data_in,
    input serial_data_out
  );
endinterface
`default_nettype wire

// ### src/vgc_device.sv
// device end: interface decode, registers, gain curve and thermal actions
// assumes all link pins are asynchronous to clk_i
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module vgc_device
  import vgc_pkg::*;
#(
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  vgc_link_if.dev link,
  input wire logic [3:0] junction_temp_i,
  output logic [5:0] atten_level_o,
  output logic rf_on_o,
  output logic amp_on_o,
  output logic atten_on_o,
  output logic temp_sensor_on_o,
  output logic over_temp_o
);
  // ==========================================================
  // input synchronisers
  logic [16:0] sync1, sync2;
  logic le_d, sclk_d;
  wire [16:0] raw_in = {link.interface_select_pin, link.spi_variant_pin,
    link.powerup_gain_hi, link.powerup_gain_lo, link.latch_enable_select,
    link.spi_clk, link.serial_data_in, link.gain_word_bits, junction_temp_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // latch strobe bit starts at its idle high level, no false edge
      sync1 <= 17'h01000;
      sync2 <= 17'h01000;
      le_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      le_d <= sync2[12];
      sclk_d <= sync2[11];
    end
  end

  wire isel = sync2[16];
  wire variant = sync2[15];
  wire pup_hi = sync2[14];
  wire pup_lo = sync2[13];
  wire le = sync2[12];
  wire sclk = sync2[11];
  wire sdi = sync2[10];
  wire [5:0] gword = sync2[9:4];
  wire [3:0] jtemp = sync2[3:0];

  wire mode_par = ~isel; // [RULE1]
  wire mode_basic = isel & variant; // [RULE1]
  wire mode_ext = isel & ~variant; // [RULE1]
  wire le_rise = le & ~le_d;
  wire shift_en = sclk & ~sclk_d & ~le & isel; // [RULE23]

  // ==========================================================
  // serial shifters
  logic [5:0] sh6;
  logic [15:0] sh16;
  logic [4:0] bitcnt;
  logic read_act;
  logic [7:0] rdval;
  logic sdo;
  wire [7:0] next_rd;

  wire [7:0] next_cmd = {sh16[6:0], sdi};
  wire [7:0] cmd = sh16[15:8];
  wire [7:0] dat = sh16[7:0];
  wire frame_ok = mode_ext & le_rise & (bitcnt == FRAME_BITS); // [RULE8]
  wire do_write = frame_ok & ~dat[RW_BIT]; // [RULE9]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh6 <= 6'h00;
      sh16 <= 16'h0000;
      bitcnt <= 5'h00;
      read_act <= 1'b0;
      rdval <= 8'h00;
    end else if (le) begin
      bitcnt <= 5'h00;
      read_act <= 1'b0;
    end else if (shift_en) begin
      sh6 <= {sh6[4:0], sdi}; // [RULE5] [RULE6]
      sh16 <= {sh16[14:0], sdi}; // [RULE8]
      if (bitcnt != 5'h1f) begin
        bitcnt <= bitcnt + 5'h01;
      end
      if (bitcnt == CMD_BITS - 5'h01) begin
        rdval <= next_rd;
      end else if (read_act) begin
        rdval <= {rdval[6:0], 1'b0};
      end
      if (mode_ext && bitcnt == CMD_BITS && sdi) begin
        read_act <= 1'b1; // [RULE9]
      end
    end
  end

  // displaced bits out, or register contents during a read
  wire next_sdo = mode_basic ? sh6[5] : (read_act ? rdval[6] : sh16[15]); // [RULE10] [RULE23]

  // ==========================================================
  // register file
  logic [5:0] gain_sel;
  logic [6:0] tcfg;
  logic [5:0] en;
  logic [3:0] temp_code;
  logic [5:0] gain_lookup_table [64];
  logic boot_done;
  logic [1:0] boot_cnt;

  // curve-entry command test, shared by read and write decode
  function automatic logic is_curve(input logic [7:0] c);
    is_curve = (c[7:6] == CMD_CURVE_TOP);
  endfunction

  wire [5:0] preset_word = vgc_preset(pup_hi, pup_lo); // [RULE21]
  wire boot_load = (boot_cnt == BOOT_WAIT);
  wire [5:0] boot_word = (le & mode_par) ? gword : preset_word; // [RULE22]
  wire [5:0] lut_rd = gain_lookup_table[next_cmd[5:0]];
  // read value chosen from the command byte as it completes
  assign next_rd =
    (next_cmd == CMD_GAIN_SELECT) ? {2'h0, gain_sel} :
    (next_cmd == CMD_TEMP_CODE) ? (TEMP_STATUS_FLAG | {4'h0, temp_code}) : // [RULE12] [RULE13]
    (next_cmd == CMD_THERMAL_CFG) ? {1'b0, tcfg} :
    (next_cmd == CMD_BLOCK_EN) ? {2'h0, en} :
    (next_cmd == CMD_PART_ID) ? PART_ID : // [RULE20]
    is_curve(next_cmd) ? {2'h0, lut_rd} : 8'h00;
  wire curve_wr = do_write & is_curve(cmd); // [RULE19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_sel <= GAIN_RESET; // [RULE11]
      tcfg <= CFG_RESET; // [RULE14]
      en <= EN_RESET; // [RULE18]
      boot_done <= 1'b0;
      boot_cnt <= 2'h0;
    end else if (!boot_done) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_load) begin
        boot_done <= 1'b1;
        gain_sel <= boot_word; // [RULE22]
      end
    end else if (mode_par && le) begin
      gain_sel <= gword; // [RULE2] [RULE3]
    end else if (mode_basic && le_rise) begin
      gain_sel <= sh6; // [RULE7]
    end else if (do_write) begin
      if (cmd == CMD_GAIN_SELECT) begin
        gain_sel <= dat[5:0]; // [RULE11]
      end
      if (cmd == CMD_THERMAL_CFG) begin
        tcfg <= dat[6:0]; // [RULE14]
      end
      if (cmd == CMD_BLOCK_EN) begin
        en <= dat[5:0]; // [RULE18]
      end
    end
  end

  // curve memory, linear after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 64; i++) begin
        gain_lookup_table[i] <= 6'(i); // [RULE19]
      end
    end else if (curve_wr) begin
      gain_lookup_table[cmd[5:0]] <= dat[5:0]; // [RULE19]
    end
  end

  // ==========================================================
  // thermal protection and outputs
  // preset gain outranks min gain; rf cut-off stands apart
  wire ovt = en[EN_TS_BIT] & (temp_code > tcfg[3:0]);
  wire [5:0] eff_word = (ovt & tcfg[CFG_PG_BIT]) ? preset_word : // [RULE16]
    (ovt & tcfg[CFG_MG_BIT]) ? MIN_GAIN_WORD : gain_sel; // [RULE17]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_code <= 4'h0;
      sdo <= 1'b0;
      atten_level_o <= 6'h00;
      rf_on_o <= 1'b0;
      amp_on_o <= 1'b0;
      atten_on_o <= 1'b0;
      temp_sensor_on_o <= 1'b0;
      over_temp_o <= 1'b0;
    end else begin
      if (en[EN_TS_BIT]) begin
        temp_code <= jtemp; // [RULE13]
      end
      sdo <= next_sdo;
      atten_level_o <= gain_lookup_table[eff_word]; // [RULE4]
      rf_on_o <= en[EN_AM_BIT] & ~(ovt & tcfg[CFG_RF_BIT]); // [RULE15]
      amp_on_o <= en[EN_AM_BIT]; // [RULE18]
      atten_on_o <= en[EN_AT_BIT]; // [RULE18]
      temp_sensor_on_o <= en[EN_TS_BIT]; // [RULE18]
      over_temp_o <= ovt;
    end
  end

  assign link.serial_data_out = sdo;
endmodule
`default_nettype wire

// ### src/vgc_host.sv
// host end: wishbone registers driving straps, parallel word and serial frames
// assumes a classic wishbone master on clk_i
`timescale 1ns/100ps
`default_nettype none
module vgc_host
  import vgc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  vgc_link_if.host link
);
  // ==========================================================
  // register access
  logic [4:0] ctrl;
  logic [5:0] par;
  logic [15:0] tx;
  logic [4:0] len;
  logic [15:0] rx;
  vgc_state_t state;
  logic start;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [1:0] idx = wb_adr_i[3:2];
  wire busy = (state != VGC_IDLE) | start;
  wire [31:0] m_ctrl = vgc_merge({27'h0, ctrl}, wb_dat_i, wb_sel_i);
  wire [31:0] m_par = vgc_merge({26'h0, par}, wb_dat_i, wb_sel_i);
  wire [31:0] m_tx = vgc_merge({11'h0, len, tx}, wb_dat_i, wb_sel_i);
  wire [31:0] rd_mux = (idx == HREG_CTRL) ? {27'h0, ctrl} :
    (idx == HREG_PAR) ? {26'h0, par} :
    (idx == HREG_TX) ? {11'h0, len, tx} : {15'h0, busy, rx};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      par <= 6'h00;
      tx <= 16'h0000;
      len <= FRAME_BITS;
      start <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
      start <= 1'b0;
      if (wr && idx == HREG_CTRL) begin
        ctrl <= m_ctrl[4:0]; // [RULE1]
      end
      if (wr && idx == HREG_PAR) begin
        par <= m_par[5:0];
      end
      if (wr && idx == HREG_TX && !busy) begin
        tx <= m_tx[15:0];
        len <= (m_tx[20:16] == 5'h0 || m_tx[20:16] > FRAME_BITS) ? FRAME_BITS : m_tx[20:16];
        start <= 1'b1;
      end
    end
  end

  // ==========================================================
  // serial engine
  logic sdo_s1, sdo_s2;
  logic [2:0] cnt;
  logic [4:0] left;
  logic sclk, sdi, le;
  wire half_done = (cnt == 3'(SCLK_HALF_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
      state <= VGC_IDLE;
      cnt <= 3'h0;
      left <= 5'h00;
      rx <= 16'h0000;
      sclk <= 1'b0;
      sdi <= 1'b0;
      le <= 1'b1;
    end else begin
      sdo_s1 <= link.serial_data_out;
      sdo_s2 <= sdo_s1;
      cnt <= half_done ? 3'h0 : cnt + 3'h1;
      case (state)
        VGC_IDLE: begin
          le <= ctrl[CTRL_LE_BIT]; // [RULE2] [RULE3]
          cnt <= 3'h0;
          if (start) begin
            le <= 1'b0;
            sdi <= tx[4'(len - 5'h01)]; // [RULE23] [RULE6]
            left <= len;
            state <= VGC_LOW;
          end
        end
        VGC_LOW: begin
          if (half_done) begin
            sclk <= 1'b1;
            rx <= {rx[14:0], sdo_s2}; // [RULE10]
            state <= VGC_HIGH;
          end
        end
        VGC_HIGH: begin
          if (half_done) begin
            sclk <= 1'b0;
            left <= left - 5'h01;
            if (left == 5'h01) begin
              state <= VGC_LATCH;
            end else begin
              sdi <= tx[4'(left - 5'h02)]; // [RULE8] [RULE9]
              state <= VGC_LOW;
            end
          end
        end
        VGC_LATCH: begin
          if (half_done) begin
            le <= 1'b1; // [RULE7]
            state <= VGC_IDLE;
          end
        end
        default: begin
          state <= VGC_IDLE;
        end
      endcase
    end
  end

  assign link.interface_select_pin = ctrl[CTRL_ISEL_BIT];
  assign link.spi_variant_pin = ctrl[CTRL_VAR_BIT];
  assign link.powerup_gain_hi = ctrl[CTRL_PUPHI_BIT];
  assign link.powerup_gain_lo = ctrl[CTRL_PUPLO_BIT];
  assign link.latch_enable_select = le;
  assign link.gain_word_bits = par;
  assign link.spi_clk = sclk;
  assign link.serial_data_in = sdi;
endmodule
`default_nettype wire

// ### verification/vgc_monitor.sv
// assertion checker on the pins between host and device
// assumes instantiation beside the link interface in the bench
`timescale 1ns/100ps
`default_nettype none
module vgc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic interface_select_pin,
  input wire logic spi_variant_pin,
  input wire logic latch_enable_select,
  input wire logic spi_clk,
  input wire logic serial_data_in
);
  // ==========================================================
  // link timing
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence clk_high_s;
    spi_clk [*4] ##1 !spi_clk;
  endsequence
  sequence clk_low_s;
    !spi_clk [*4] ##1 spi_clk;
  endsequence
  sequence gap_s;
    (!spi_clk && !latch_enable_select) [*4] ##1 (spi_clk || latch_enable_select);
  endsequence

  idle_level_a: assert property ($fell(rst_i) |-> latch_enable_select && !spi_clk)
    else $error("link not idle after reset");
  clk_still_a: assert property (latch_enable_select |-> !spi_clk)
    else $error("serial clock runs outside a frame");
  frame_start_a: assert property ($fell(latch_enable_select) && interface_select_pin |->
    clk_low_s)
    else $error("first clock edge misplaced");
  high_time_a: assert property ($rose(spi_clk) |-> clk_high_s)
    else $error("clock high phase wrong");
  bit_gap_a: assert property ($fell(spi_clk) |-> gap_s)
    else $error("clock low phase or frame end wrong");
  data_hold_a: assert property ($rose(spi_clk) |=> $stable(serial_data_in) [*3])
    else $error("serial data moved while clock high");
  mode_hold_a: assert property (!latch_enable_select && interface_select_pin |->
    $stable(interface_select_pin) && $stable(spi_variant_pin))
    else $error("mode pins moved inside a frame");
  par_quiet_a: assert property (!interface_select_pin |-> !spi_clk)
    else $error("serial clock in parallel mode");
endmodule
`default_nettype wire

// ### verification/vgc_bench.sv
// bench: host and device joined by the link interface, driven over wishbone
// assumes the design sources and the link monitor are compiled first
`timescale 1ns/100ps
`default_nettype none
module vgc_bench;
  import vgc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_d = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] jt = 4'h5;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [5:0] atten;
  logic rf_on;
  logic amp_on;
  logic at_on;
  logic ts_on;
  logic ot;
  logic [5:0] preset_tab [4] = '{6'h00, 6'h0f, 6'h1f, 6'h3f};
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  vgc_link_if lnk ();
  vgc_host u_vgc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(lnk.host));
  vgc_device u_vgc_device (.clk_i(clk_i), .rst_i(rst_d), .link(lnk.dev),
    .junction_temp_i(jt), .atten_level_o(atten), .rf_on_o(rf_on), .amp_on_o(amp_on),
    .atten_on_o(at_on), .temp_sensor_on_o(ts_on), .over_temp_o(ot));
  vgc_monitor u_vgc_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .interface_select_pin(lnk.interface_select_pin), .spi_variant_pin(lnk.spi_variant_pin),
    .latch_enable_select(lnk.latch_enable_select), .spi_clk(lnk.spi_clk),
    .serial_data_in(lnk.serial_data_in));

  // ==========================================================
  // clock and timeout
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic frame(input logic [4:0] len, input logic [15:0] bits);
    wb(4'h8, 1'b1, {11'h0, len, bits});
    wb(4'hc, 1'b0, 32'h0);
    while (q[STAT_BUSY_BIT] === 1'b1) wb(4'hc, 1'b0, 32'h0);
    settle();
  endtask
  task automatic put(input logic [7:0] cmd, input logic [6:0] d);
    frame(5'h10, {cmd, 1'b0, d});
  endtask
  task automatic get(input logic [7:0] cmd, input logic [6:0] exp, input string name);
    frame(5'h10, {cmd, 8'h80});
    check(name, {1'b0, q[6:0]}, {1'b0, exp});
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rst_d <= 1'b0;
    repeat (20) @(posedge clk_i);
    check("boot gain", {2'h0, atten}, 8'h00);
    wb(4'h4, 1'b1, 32'h2a);
    settle();
    check("par follow", {2'h0, atten}, 8'h2a);
    wb(4'h0, 1'b1, 32'h0);
    wb(4'h4, 1'b1, 32'h3f);
    settle();
    check("par hold", {2'h0, atten}, 8'h2a);
    wb(4'h0, 1'b1, 32'h10);
    settle();
    check("par all ones", {2'h0, atten}, 8'h3f);
    $display("test parallel done");
    wb(4'h0, 1'b1, 32'h13);
    frame(5'h0c, {4'h0, 6'h31, 6'h0e});
    check("chain word", {2'h0, atten}, 8'h0e);
    check("chain out", {2'h0, q[5:0]}, 8'h31);
    $display("test basic done");
    for (int k = 0; k < 4; k++) begin
      wb(4'h0, 1'b1, {27'h0, 1'b1, k[1:0], 2'b01});
      rst_d <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_d <= 1'b0;
      repeat (20) @(posedge clk_i);
      check("strap gain", {2'h0, atten}, {2'h0, preset_tab[k]});
    end
    $display("test straps done");
    put(CMD_GAIN_SELECT, 7'h25);
    check("ext write", {2'h0, atten}, 8'h25);
    frame(5'h0f, 16'h0005);
    check("short frame", {2'h0, atten}, 8'h25);
    get(CMD_GAIN_SELECT, 7'h25, "gain read");
    get(CMD_BLOCK_EN, 7'h3f, "enable reset");
    get(CMD_THERMAL_CFG, 7'h00, "cfg reset");
    get(CMD_PART_ID, PART_ID_DEFAULT[6:0], "part id");
    get(CMD_TEMP_CODE, 7'h05, "temp code");
    put(8'ha5, 7'h07);
    check("curve write", {2'h0, atten}, 8'h07);
    get(8'hbf, 7'h3f, "curve linear");
    put(CMD_THERMAL_CFG, 7'h15);
    check("at threshold", {7'h0, ot}, 8'h00);
    check("no action", {2'h0, atten}, 8'h07);
    put(CMD_THERMAL_CFG, 7'h14);
    check("over temp", {7'h0, ot}, 8'h01);
    check("min gain", {2'h0, atten}, 8'h00);
    put(CMD_THERMAL_CFG, 7'h24);
    check("preset gain", {2'h0, atten}, 8'h3f);
    put(CMD_THERMAL_CFG, 7'h44);
    check("rf off", {7'h0, rf_on}, 8'h00);
    check("rf gain", {2'h0, atten}, 8'h07);
    put(CMD_THERMAL_CFG, 7'h09);
    check("rf back", {7'h0, rf_on}, 8'h01);
    put(CMD_BLOCK_EN, 7'h03);
    check("atten off", {7'h0, at_on}, 8'h00);
    check("amp on", {7'h0, amp_on}, 8'h01);
    check("sensor on", {7'h0, ts_on}, 8'h01);
    put(CMD_BLOCK_EN, 7'h06);
    check("sensor off", {7'h0, ts_on}, 8'h00);
    check("atten on", {7'h0, at_on}, 8'h01);
    put(CMD_THERMAL_CFG, 7'h14);
    check("no sensor trip", {7'h0, ot}, 8'h00);
    check("no sensor gain", {2'h0, atten}, 8'h07);
    $display("test extended done");
    complete_run();
  end
endmodule
`default_nettype wire
